// ==== hw/pmr_pkg.sv ====
// Package of constants and carrier types for the PHY management register set.
`default_nettype none
package pmr_pkg;

  // Register offsets on the management port.
  localparam logic [4:0] PMR_OFF_PARTNER = 5'h05;
  localparam logic [4:0] PMR_OFF_EXPAN   = 5'h06;
  localparam logic [4:0] PMR_OFF_USC     = 5'h10;
  localparam logic [4:0] PMR_OFF_STC     = 5'h11;
  localparam logic [4:0] PMR_OFF_ADDR    = 5'h12;

  // Expansion register field positions.
  localparam int PMR_EXP_PDF  = 4;
  localparam int PMR_EXP_LPNP = 3;
  localparam int PMR_EXP_NPA  = 2;
  localparam int PMR_EXP_PR   = 1;
  localparam int PMR_EXP_LPAN = 0;

  // Unit status/control field positions.
  localparam int PMR_USC_CSD  = 13;
  localparam int PMR_USC_TFC  = 12;
  localparam int PMR_USC_SYNC = 11;
  localparam int PMR_USC_PD100 = 10;
  localparam int PMR_USC_PD10 = 9;
  localparam int PMR_USC_POL  = 8;
  localparam int PMR_USC_SPD  = 1;
  localparam int PMR_USC_DPX  = 0;

  // Partner ability acknowledge position.
  localparam int PMR_PA_ACK = 14;

  // Writable masks of the status/control and special control registers, special control reset value, PHY address.
  localparam logic [15:0] PMR_USC_WMASK = 16'h3000;
  localparam logic [15:0] PMR_STC_RESET = 16'h0000;
  localparam logic [15:0] PMR_STC_WMASK = 16'hFBFF;
  localparam logic [4:0]  PMR_PHY_ADDR  = 5'h01;

  // Control outputs decoded from the special control and status/control registers.
  typedef struct packed {
    logic scr_bypass;
    logic code_bypass;
    logic force_h;
    logic force_34;
    logic force_link_good;
    logic tx_crs_disable;
    logic dyn_pd_disable;
    logic an_loopback;
    logic tx_tristate;
    logic filter_bypass;
    logic auto_pol_disable;
    logic squelch_disable;
    logic ext_squelch;
    logic link_int_disable;
    logic jabber_disable;
    logic crs_disconnect_en;
    logic tx_flow_en;
  } pmr_ctrl_t;

  // Status inputs from the PHY core.
  typedef struct packed {
    logic [15:0] partner_page;
    logic        page_ack;
    logic        pdf_event;
    logic        page_event;
    logic        lp_np_able;
    logic        np_able;
    logic        lp_an_able;
    logic        desync_ok;
    logic        pd_100;
    logic        pd_10;
    logic        pol_rev;
    logic        speed_100;
    logic        full_dpx;
  } pmr_stat_t;

  // All state of the register block.
  typedef struct packed {
    logic [15:0] rdata;
    logic        pdf;
    logic        pr;
    logic [1:0]  usc_ctl;
    logic [15:0] stc;
  } pmr_state_t;

endpackage
`default_nettype wire

// ==== hw/pmr_regs.sv ====
// Management register set: partner, expansion, status/control, special control, address.
`timescale 1ns/1ps
`default_nettype none
module pmr_regs (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [4:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [15:0]            rdata,
  input  wire pmr_pkg::pmr_stat_t stat,
  output var pmr_pkg::pmr_ctrl_t ctrl
);
  import pmr_pkg::*;

  // Reset image of the whole state, so the reset branch makes one constant assignment.
  localparam pmr_state_t ST_RESET = '{rdata: 16'h0000, pdf: 1'b0, pr: 1'b0,
                                      usc_ctl: 2'b00, stc: PMR_STC_RESET};

  pmr_state_t st_reg;    // Registered state.
  pmr_state_t st_next;   // Next state.
  logic [15:0] rd_val;   // Value that a read in this cycle returns.
  logic [15:0] pa_val;   // Partner ability word.
  logic [15:0] ex_val;   // Expansion word.
  logic [15:0] us_val;   // Status/control word.

  // Build the readable words from live status and stored control.
  always_comb
  begin
    pa_val = stat.partner_page;
    pa_val[PMR_PA_ACK] = stat.page_ack;
    ex_val = 16'h0000;
    ex_val[PMR_EXP_PDF]  = st_reg.pdf;
    ex_val[PMR_EXP_PR]   = st_reg.pr;
    ex_val[PMR_EXP_LPNP] = stat.lp_np_able;
    ex_val[PMR_EXP_NPA]  = stat.np_able;
    ex_val[PMR_EXP_LPAN] = stat.lp_an_able;
    us_val = 16'h0000;
    us_val[PMR_USC_CSD]   = st_reg.usc_ctl[1];
    us_val[PMR_USC_TFC]   = st_reg.usc_ctl[0];
    us_val[PMR_USC_SYNC]  = stat.desync_ok;
    us_val[PMR_USC_PD100] = stat.pd_100;
    us_val[PMR_USC_PD10]  = stat.pd_10;
    us_val[PMR_USC_POL]   = stat.pol_rev;
    us_val[PMR_USC_SPD]   = stat.speed_100;
    us_val[PMR_USC_DPX]   = stat.full_dpx;
    // Unmapped offsets read as zero.
    case (addr)
      PMR_OFF_PARTNER: rd_val = pa_val;
      PMR_OFF_EXPAN:   rd_val = ex_val;
      PMR_OFF_USC:     rd_val = us_val;
      PMR_OFF_STC:     rd_val = st_reg.stc;
      PMR_OFF_ADDR:    rd_val = {11'h000, PMR_PHY_ADDR};
      default:         rd_val = 16'h0000;
    endcase
  end

  // Next state: read capture, latched flags, writes.
  always_comb
  begin
    st_next = st_reg;
    if (rd)
    begin
      st_next.rdata = rd_val;
    end
    // The read samples the flag first; the clear only drops what was shown,
    // and a new event in the same cycle sets it again.
    if (rd && addr == PMR_OFF_EXPAN)
    begin
      st_next.pdf = 1'b0;
      st_next.pr  = 1'b0;
    end
    if (stat.pdf_event)
    begin
      st_next.pdf = 1'b1;
    end
    if (stat.page_event)
    begin
      st_next.pr = 1'b1;
    end
    if (wr && addr == PMR_OFF_USC)
    begin
      st_next.usc_ctl = {wdata[PMR_USC_CSD], wdata[PMR_USC_TFC]};
    end
    if (wr && addr == PMR_OFF_STC)
    begin
      st_next.stc = wdata & PMR_STC_WMASK;
    end
  end

  // State register with asynchronous reset.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;

  // Control outputs straight from the stored bits.
  always_comb
  begin
    ctrl.scr_bypass        = st_reg.stc[15];
    ctrl.code_bypass       = st_reg.stc[14];
    ctrl.force_h           = st_reg.stc[13];
    ctrl.force_34          = st_reg.stc[12];
    ctrl.force_link_good   = st_reg.stc[11];
    ctrl.tx_crs_disable    = st_reg.stc[9];
    ctrl.dyn_pd_disable    = st_reg.stc[8];
    ctrl.an_loopback       = st_reg.stc[7];
    ctrl.tx_tristate       = st_reg.stc[6];
    ctrl.filter_bypass     = st_reg.stc[5];
    ctrl.auto_pol_disable  = st_reg.stc[4];
    ctrl.squelch_disable   = st_reg.stc[3];
    ctrl.ext_squelch       = st_reg.stc[2];
    ctrl.link_int_disable  = st_reg.stc[1];
    ctrl.jabber_disable    = st_reg.stc[0];
    ctrl.crs_disconnect_en = st_reg.usc_ctl[1];
    ctrl.tx_flow_en        = st_reg.usc_ctl[0];
  end

  // Checks.
  property p_pr_set;
    @(posedge clk) disable iff (!resetn) stat.page_event |=> st_reg.pr;
  endproperty
  a_pr_set: assert property (p_pr_set) else $error("page flag not set");

  property p_pdf_set;
    @(posedge clk) disable iff (!resetn) stat.pdf_event |=> st_reg.pdf;
  endproperty
  a_pdf_set: assert property (p_pdf_set) else $error("fault flag not set");

  property p_pr_clr;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_EXPAN && !stat.page_event) |=> !st_reg.pr;
  endproperty
  a_pr_clr: assert property (p_pr_clr) else $error("page flag not cleared");

  property p_rd_flag;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_EXPAN) |=> rdata[PMR_EXP_PR] == $past(st_reg.pr);
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("flag value lost on read");

  property p_addr;
    @(posedge clk) disable iff (!resetn) (rd && addr == PMR_OFF_ADDR) |=> rdata == 16'h0001;
  endproperty
  a_addr: assert property (p_addr) else $error("address register wrong");

  property p_stc_wr;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.scr_bypass == $past(wdata[15])
        && ctrl.jabber_disable == $past(wdata[0]);
  endproperty
  a_stc_wr: assert property (p_stc_wr) else $error("special control not stored");

  property p_flow;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_USC) |=> ctrl.tx_flow_en == $past(wdata[12]);
  endproperty
  a_flow: assert property (p_flow) else $error("flow control bit wrong");

  property p_csd;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_USC) |=> ctrl.crs_disconnect_en == $past(wdata[13]);
  endproperty
  a_csd: assert property (p_csd) else $error("disconnect bit wrong");

  property p_ack;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_PARTNER) |=> rdata[14] == $past(stat.page_ack);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge bit wrong");

  // Partner page fields pass through untouched apart from the acknowledge bit.
  property p_pa_np;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_PARTNER) |=> rdata[15] == $past(stat.partner_page[15]);
  endproperty
  a_pa_np: assert property (p_pa_np) else $error("next page bit wrong");

  property p_pa_low;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_PARTNER) |=> rdata[13:0] == $past(stat.partner_page[13:0]);
  endproperty
  a_pa_low: assert property (p_pa_low) else $error("partner fields wrong");

  // Expansion word: the fault flag is shown before it is cleared.
  property p_pdf_rd;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_EXPAN) |=> rdata[PMR_EXP_PDF] == $past(st_reg.pdf);
  endproperty
  a_pdf_rd: assert property (p_pdf_rd) else $error("fault flag lost on read");

  property p_pdf_clr;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_EXPAN && !stat.pdf_event) |=> !st_reg.pdf;
  endproperty
  a_pdf_clr: assert property (p_pdf_clr) else $error("fault flag not cleared");

  property p_lpnp;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_EXPAN) |=> rdata[PMR_EXP_LPNP] == $past(stat.lp_np_able);
  endproperty
  a_lpnp: assert property (p_lpnp) else $error("partner next page bit wrong");

  property p_npa;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_EXPAN) |=> rdata[PMR_EXP_NPA] == $past(stat.np_able);
  endproperty
  a_npa: assert property (p_npa) else $error("local next page bit wrong");

  property p_lpan;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_EXPAN) |=> rdata[PMR_EXP_LPAN] == $past(stat.lp_an_able);
  endproperty
  a_lpan: assert property (p_lpan) else $error("partner autoneg bit wrong");

  property p_exp_rsv;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_EXPAN) |=> rdata[15:5] == 11'h000;
  endproperty
  a_exp_rsv: assert property (p_exp_rsv) else $error("expansion upper bits set");

  // Status/control word: live status levels and stored control bits at their fixed positions.
  property p_sync;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_USC) |=> rdata[PMR_USC_SYNC] == $past(stat.desync_ok);
  endproperty
  a_sync: assert property (p_sync) else $error("in-sync bit wrong");

  property p_pd100;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_USC) |=> rdata[PMR_USC_PD100] == $past(stat.pd_100);
  endproperty
  a_pd100: assert property (p_pd100) else $error("fast unit power bit wrong");

  property p_pd10;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_USC) |=> rdata[PMR_USC_PD10] == $past(stat.pd_10);
  endproperty
  a_pd10: assert property (p_pd10) else $error("slow unit power bit wrong");

  property p_pol;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_USC) |=> rdata[PMR_USC_POL] == $past(stat.pol_rev);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity bit wrong");

  property p_spd;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_USC) |=> rdata[PMR_USC_SPD] == $past(stat.speed_100);
  endproperty
  a_spd: assert property (p_spd) else $error("speed bit wrong");

  property p_dpx;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_USC) |=> rdata[PMR_USC_DPX] == $past(stat.full_dpx);
  endproperty
  a_dpx: assert property (p_dpx) else $error("duplex bit wrong");

  property p_usc_ctl;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_USC) |=> rdata[13:12] == $past(st_reg.usc_ctl);
  endproperty
  a_usc_ctl: assert property (p_usc_ctl) else $error("control bits read wrong");

  // Special control word reads back what was stored, and only a write changes it.
  property p_stc_rd;
    @(posedge clk) disable iff (!resetn)
      (rd && addr == PMR_OFF_STC) |=> rdata == $past(st_reg.stc);
  endproperty
  a_stc_rd: assert property (p_stc_rd) else $error("special control read wrong");

  property p_stc_rsv;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> st_reg.stc[10] == 1'b0;
  endproperty
  a_stc_rsv: assert property (p_stc_rsv) else $error("reserved bit stored");

  property p_stc_hold;
    @(posedge clk) disable iff (!resetn)
      !(wr && addr == PMR_OFF_STC) |=> $stable(st_reg.stc);
  endproperty
  a_stc_hold: assert property (p_stc_hold) else $error("special control changed");

  property p_unmapped;
    @(posedge clk) disable iff (!resetn)
      (rd && addr != PMR_OFF_PARTNER && addr != PMR_OFF_EXPAN && addr != PMR_OFF_USC
        && addr != PMR_OFF_STC && addr != PMR_OFF_ADDR) |=> rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Each control output of the special control register follows its own bit of a special control write.
  property p_code;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.code_bypass == $past(wdata[14]);
  endproperty
  a_code: assert property (p_code) else $error("coding bypass wrong");

  property p_forceh;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.force_h == $past(wdata[13]);
  endproperty
  a_forceh: assert property (p_forceh) else $error("h pattern bit wrong");

  property p_force34;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.force_34 == $past(wdata[12]);
  endproperty
  a_force34: assert property (p_force34) else $error("34 pattern bit wrong");

  property p_lgood;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.force_link_good == $past(wdata[11]);
  endproperty
  a_lgood: assert property (p_lgood) else $error("link good bit wrong");

  property p_txcrs;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.tx_crs_disable == $past(wdata[9]);
  endproperty
  a_txcrs: assert property (p_txcrs) else $error("carrier sense bit wrong");

  property p_dynpd;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.dyn_pd_disable == $past(wdata[8]);
  endproperty
  a_dynpd: assert property (p_dynpd) else $error("power-down bit wrong");

  property p_anlb;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.an_loopback == $past(wdata[7]);
  endproperty
  a_anlb: assert property (p_anlb) else $error("loopback bit wrong");

  property p_tri;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.tx_tristate == $past(wdata[6]);
  endproperty
  a_tri: assert property (p_tri) else $error("driver off bit wrong");

  property p_filt;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.filter_bypass == $past(wdata[5]);
  endproperty
  a_filt: assert property (p_filt) else $error("filter bypass bit wrong");

  property p_apol;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.auto_pol_disable == $past(wdata[4]);
  endproperty
  a_apol: assert property (p_apol) else $error("auto polarity bit wrong");

  property p_sq;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.squelch_disable == $past(wdata[3]);
  endproperty
  a_sq: assert property (p_sq) else $error("squelch bit wrong");

  property p_xsq;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.ext_squelch == $past(wdata[2]);
  endproperty
  a_xsq: assert property (p_xsq) else $error("extended squelch bit wrong");

  property p_lint;
    @(posedge clk) disable iff (!resetn)
      (wr && addr == PMR_OFF_STC) |=> ctrl.link_int_disable == $past(wdata[1]);
  endproperty
  a_lint: assert property (p_lint) else $error("link integrity bit wrong");

endmodule // pmr_regs
`default_nettype wire

// ==== sim/pmr_partner.sv ====
// Far-side model: PHY core status and link partner page for the register set.
`timescale 1ns/1ps
`default_nettype none
module pmr_partner (
  input  wire logic [15:0]       page,
  input  wire logic [9:0]        lv,
  input  wire logic [1:0]        ev,
  output var pmr_pkg::pmr_stat_t stat
);
  import pmr_pkg::*;
  // Page, ack and levels pass straight through; events are one-cycle pulses.
  always_comb
  begin
    stat = {page, lv[9], ev, lv[8:0]};
  end
endmodule // pmr_partner
`default_nettype wire

// ==== sim/pmr_regs_test.sv ====
// Self-checking bench for the PHY management register set.
`timescale 1ns/1ps
`default_nettype none
module pmr_regs_test;
  import pmr_pkg::*;
  typedef struct packed {logic [4:0] a; logic w; logic [15:0] d; logic [15:0] e;} pmr_row_t;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] page = 16'hA5E1;  // Bit 14 low, so the ack input alone sets it.
  logic [9:0]  lv = 10'h018;     // Both units powered down, as after reset.
  logic [1:0]  ev = 2'b00;
  logic [15:0] stc_m = 16'h0000;
  logic [15:0] usc_m = 16'h0000;
  pmr_stat_t   stat;
  pmr_ctrl_t   ctrl;
  int          fail_count = 0;
  int          check_count = 0;
  pmr_row_t    rows [8] = '{
    '{5'h11, 1'b1, 16'hFFFF, 16'hFBFF}, '{5'h11, 1'b1, 16'hA5A5, 16'hA1A5},
    '{5'h10, 1'b1, 16'hFFFF, 16'h3A02}, '{5'h10, 1'b1, 16'h0000, 16'h0A02},
    '{5'h12, 1'b1, 16'hFFFF, 16'h0001}, '{5'h05, 1'b1, 16'h0000, 16'hE5E1},
    '{5'h06, 1'b1, 16'hFFFF, 16'h0009}, '{5'h1F, 1'b0, 16'h0000, 16'h0000}};

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk = ~clk;

  pmr_regs uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                .rdata(rdata), .stat(stat), .ctrl(ctrl));
  pmr_partner far_end (.page(page), .lv(lv), .ev(ev), .stat(stat));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_ctrl(input pmr_ctrl_t exp);
    check_count++;
    if (ctrl !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, ctrl, exp);
    end
  endtask

  // Strobes last one cycle; the read task samples just after the answering edge.
  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // About 60 cycles are needed, so 5 us means a hang.
  initial
  begin
    #5000;
    fail_count++;
    complete_run();
  end

  initial
  begin
    logic [15:0] q;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    bus_rd(5'h11, q);
    chk(q, 16'h0000);
    bus_rd(5'h06, q);
    chk(q, 16'h0000);
    bus_rd(5'h10, q);
    chk(q, 16'h0600);
    chk_ctrl('0);
    @(posedge clk);
    lv <= 10'h36A;
    // Each row with w set writes; every row reads back and checks the decoded controls.
    foreach (rows[i])
    begin
      if (rows[i].w)
        bus_wr(rows[i].a, rows[i].d);
      if (rows[i].w && rows[i].a == 5'h11)
        stc_m = rows[i].d & 16'hFBFF;
      if (rows[i].w && rows[i].a == 5'h10)
        usc_m = rows[i].d & 16'h3000;
      bus_rd(rows[i].a, q);
      chk(q, rows[i].e);
      chk_ctrl({stc_m[15:11], stc_m[9:0], usc_m[13], usc_m[12]});
    end
    // Latched flags hold until read, then clear.
    @(posedge clk);
    ev <= 2'b11;
    @(posedge clk);
    ev <= 2'b00;
    bus_rd(5'h06, q);
    chk(q, 16'h001B);
    bus_rd(5'h06, q);
    chk(q, 16'h0009);
    // An event in the cycle of the read must survive the clear.
    @(posedge clk);
    addr <= 5'h06;
    rd <= 1'b1;
    ev <= 2'b11;
    @(posedge clk);
    rd <= 1'b0;
    ev <= 2'b00;
    bus_rd(5'h06, q);
    chk(q, 16'h001B);
    // Opposite status levels: reversed polarity, no ack.
    @(posedge clk);
    lv <= 10'h115;
    bus_rd(5'h10, q);
    chk(q, 16'h0501);
    bus_rd(5'h05, q);
    chk(q, 16'hA5E1);
    // A reset in mid-run clears the writable bits.
    bus_wr(5'h11, 16'hFFFF);
    resetn <= 1'b0;
    @(posedge clk);
    #1 chk_ctrl('0);
    @(posedge clk);
    resetn <= 1'b1;
    bus_rd(5'h11, q);
    chk(q, 16'h0000);
    complete_run();
  end
endmodule // pmr_regs_test
`default_nettype wire
